// ---- design/csto_core.v ----
`timescale 1ns/1ns
`include "csto_defines.vh"

// Functional notes
// - subtract sets acc, V N Z C only
// - subtract opcodes and cycle counts per mode
// - trap bumps pc, pushes five bytes
// - trap sets mask, loads vector, nine cycles
// - probe sets N Z, clears V, no write
// - probe opcodes and cycle counts per mode
// - wide offset high then low plus index or stack pointer
// - long address high byte first

module csto_core #(
    parameter [15:0] RESET_PC = 16'h0000,
    parameter [15:0] TRAP_VECTOR = 16'hFFFC
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // core memory bus
    input wire [7:0] mem_rdata,
    output reg [15:0] mem_addr,
    output reg [7:0] mem_wdata,
    output reg mem_re,
    output reg mem_we,
    // visible core state
    output reg [7:0] acc,
    output reg [15:0] index_reg,
    output reg [15:0] stack_ptr,
    output reg [15:0] prog_ctr,
    output reg [7:0] flag_register
);
    // ****************************************
    // sequencer states
    // ****************************************
    localparam [3:0] S_FETCH = 4'h0;
    localparam [3:0] S_PRE = 4'h1;
    localparam [3:0] S_ADH = 4'h2;
    localparam [3:0] S_ADL = 4'h3;
    localparam [3:0] S_MEM = 4'h4;
    localparam [3:0] S_PUSH = 4'h5;
    localparam [3:0] S_VECH = 4'h6;
    localparam [3:0] S_VECL = 4'h7;
    localparam [3:0] S_PAD = 4'h8;

    reg [3:0] state; // current sequencer step
    reg [1:0] base_sel; // base added to the offset bytes
    reg is_sub; // operand goes to subtract, else probe
    reg is_imm; // operand byte sits in the stream
    reg [7:0] ofs_hi; // first offset/address byte
    reg [2:0] push_step; // index of the byte being stacked
    reg [7:0] vec_hi; // vector high byte held for one cycle
    reg [7:0] push_next; // byte for the following push
    reg [15:0] base_val; // selected address base

    wire [15:0] pc_inc; // address of the next stream byte
    wire [15:0] ea_sum; // effective address from base and offset
    wire [15:0] sp_dec; // stack pointer after a push
    wire sub_sel; // subtract executes this cycle
    wire [7:0] probe_val; // value compared with zero
    wire [7:0] alu_a;
    wire [7:0] alu_b;
    wire [7:0] alu_res;
    wire alu_v;
    wire alu_n;
    wire alu_z;
    wire alu_c;

    assign pc_inc = prog_ctr + `CSTO_ONE16;
    assign sp_dec = stack_ptr - `CSTO_ONE16;
    // high byte then low byte, added to the chosen base
    assign ea_sum = base_val + {ofs_hi, mem_rdata};
    assign sub_sel = (state == S_MEM) && is_sub;
    // inherent probes look at a register, the rest at memory
    assign probe_val = (state != S_FETCH) ? mem_rdata :
        (mem_rdata == `CSTO_PROBE_ACC) ? acc : index_reg[7:0];
    // probe is value minus zero, so one subtractor serves both
    assign alu_a = sub_sel ? acc : probe_val;
    assign alu_b = sub_sel ? mem_rdata : `CSTO_ZERO8;

    // ****************************************
    // arithmetic
    // ****************************************
    csto_sub_flags #(
        .WIDTH(8)
    ) u_sub (
        .minuend(alu_a),
        .subtrahend(alu_b),
        .diff(alu_res),
        .ovf(alu_v),
        .neg(alu_n),
        .zero(alu_z),
        .borrow(alu_c)
    );

    // base for the effective address
    always @* begin
        case (base_sel)
            `CSTO_BASE_INDEX: base_val = index_reg;
            `CSTO_BASE_STACK: base_val = stack_ptr;
            default: base_val = `CSTO_ZERO16;
        endcase
    end

    // next byte to stack: pc high, index low, acc, flags
    always @* begin
        case (push_step)
            3'h0: push_next = prog_ctr[15:8];
            3'h1: push_next = index_reg[7:0];
            3'h2: push_next = acc;
            3'h3: push_next = flag_register;
            default: push_next = `CSTO_ZERO8;
        endcase
    end

    // ****************************************
    // sequencer and datapath
    // ****************************************
    // one bus cycle per state; read data answers the address of the cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_FETCH;
            base_sel <= `CSTO_BASE_ABS;
            is_sub <= 1'b0;
            is_imm <= 1'b0;
            ofs_hi <= `CSTO_ZERO8;
            push_step <= 3'h0;
            vec_hi <= `CSTO_ZERO8;
            mem_addr <= RESET_PC;
            mem_wdata <= `CSTO_ZERO8;
            mem_re <= 1'b1;
            mem_we <= 1'b0;
            acc <= `CSTO_ZERO8;
            index_reg <= `CSTO_ZERO16;
            stack_ptr <= `CSTO_STACK_RESET;
            prog_ctr <= RESET_PC;
            flag_register <= `CSTO_FLAGS_RESET;
        end else begin
            case (state)
                // opcode byte on the bus
                S_FETCH: begin
                    prog_ctr <= pc_inc;
                    mem_addr <= pc_inc;
                    mem_re <= 1'b1;
                    mem_we <= 1'b0;
                    ofs_hi <= `CSTO_ZERO8;
                    case (mem_rdata)
                        `CSTO_STACK_PREFIX: begin
                            state <= S_PRE;
                        end
                        `CSTO_SUB_IMMEDIATE: begin
                            is_sub <= 1'b1;
                            is_imm <= 1'b1;
                            state <= S_MEM;
                        end
                        `CSTO_SUB_DIRECT: begin
                            is_sub <= 1'b1;
                            base_sel <= `CSTO_BASE_ABS;
                            state <= S_ADL;
                        end
                        `CSTO_SUB_LONG: begin
                            is_sub <= 1'b1;
                            base_sel <= `CSTO_BASE_ABS;
                            state <= S_ADH;
                        end
                        `CSTO_SUB_INDEX_WIDE: begin
                            is_sub <= 1'b1;
                            base_sel <= `CSTO_BASE_INDEX;
                            state <= S_ADH;
                        end
                        `CSTO_SUB_INDEX_BYTE: begin
                            is_sub <= 1'b1;
                            base_sel <= `CSTO_BASE_INDEX;
                            state <= S_ADL;
                        end
                        `CSTO_SUB_INDEX_PLAIN: begin
                            is_sub <= 1'b1;
                            mem_addr <= index_reg;
                            state <= S_MEM;
                        end
                        `CSTO_PROBE_DIRECT: begin
                            is_sub <= 1'b0;
                            base_sel <= `CSTO_BASE_ABS;
                            state <= S_ADL;
                        end
                        `CSTO_PROBE_INDEX_BYTE: begin
                            is_sub <= 1'b0;
                            base_sel <= `CSTO_BASE_INDEX;
                            state <= S_ADL;
                        end
                        `CSTO_PROBE_INDEX_PLAIN: begin
                            is_sub <= 1'b0;
                            mem_addr <= index_reg;
                            state <= S_MEM;
                        end
                        `CSTO_PROBE_ACC, `CSTO_PROBE_INDEX: begin
                            // single cycle: flags only, no destination
                            flag_register[`CSTO_FLAG_V] <= 1'b0;
                            flag_register[`CSTO_FLAG_N] <= alu_n;
                            flag_register[`CSTO_FLAG_Z] <= alu_z;
                        end
                        `CSTO_SOFTWARE_TRAP_OP: begin
                            // first push is the low byte of pc plus one
                            mem_addr <= stack_ptr;
                            mem_wdata <= pc_inc[7:0];
                            mem_re <= 1'b0;
                            mem_we <= 1'b1;
                            push_step <= 3'h0;
                            state <= S_PUSH;
                        end
                        `CSTO_ACC_TO_FLAGS_OP: begin
                            // unused bits always read back as ones
                            flag_register <= acc | `CSTO_FLAGS_FIXED;
                            mem_re <= 1'b0;
                            state <= S_PAD;
                        end
                        `CSTO_FLAGS_TO_ACC_OP: begin
                            acc <= flag_register;
                        end
                        `CSTO_ACC_TO_INDEX_OP: begin
                            index_reg[7:0] <= acc;
                        end
                        `CSTO_INDEX_TO_ACC_OP: begin
                            acc <= index_reg[7:0];
                        end
                        `CSTO_STACK_TO_INDEX_OP: begin
                            index_reg <= stack_ptr + `CSTO_ONE16;
                            mem_re <= 1'b0;
                            state <= S_PAD;
                        end
                        `CSTO_INDEX_TO_STACK_OP: begin
                            stack_ptr <= index_reg - `CSTO_ONE16;
                            mem_re <= 1'b0;
                            state <= S_PAD;
                        end
                        // opcodes outside this slice pass as one-cycle no-ops
                        default: begin
                            state <= S_FETCH;
                        end
                    endcase
                end
                // second opcode after the stack prefix
                S_PRE: begin
                    prog_ctr <= pc_inc;
                    mem_addr <= pc_inc;
                    base_sel <= `CSTO_BASE_STACK;
                    case (mem_rdata)
                        `CSTO_SUB_STACK_BYTE: begin
                            is_sub <= 1'b1;
                            state <= S_ADL;
                        end
                        `CSTO_SUB_STACK_WIDE: begin
                            is_sub <= 1'b1;
                            state <= S_ADH;
                        end
                        `CSTO_PROBE_STACK_BYTE: begin
                            is_sub <= 1'b0;
                            state <= S_ADL;
                        end
                        default: begin
                            state <= S_FETCH;
                        end
                    endcase
                end
                // high byte of address or wide offset comes first
                S_ADH: begin
                    ofs_hi <= mem_rdata;
                    prog_ctr <= pc_inc;
                    mem_addr <= pc_inc;
                    state <= S_ADL;
                end
                // low byte completes the effective address
                S_ADL: begin
                    prog_ctr <= pc_inc;
                    mem_addr <= ea_sum;
                    state <= S_MEM;
                end
                // operand on the bus: execute
                S_MEM: begin
                    if (is_imm) begin
                        prog_ctr <= pc_inc;
                        mem_addr <= pc_inc;
                    end else begin
                        mem_addr <= prog_ctr;
                    end
                    is_imm <= 1'b0;
                    if (is_sub) begin
                        // half-carry and mask stay as they are
                        acc <= alu_res;
                        flag_register[`CSTO_FLAG_V] <= alu_v;
                        flag_register[`CSTO_FLAG_N] <= alu_n;
                        flag_register[`CSTO_FLAG_Z] <= alu_z;
                        flag_register[`CSTO_FLAG_C] <= alu_c;
                    end else begin
                        flag_register[`CSTO_FLAG_V] <= 1'b0;
                        flag_register[`CSTO_FLAG_N] <= alu_n;
                        flag_register[`CSTO_FLAG_Z] <= alu_z;
                    end
                    state <= S_FETCH;
                end
                // one stack write per cycle, pointer drops after each
                S_PUSH: begin
                    stack_ptr <= sp_dec;
                    if (push_step != `CSTO_PUSH_LAST) begin
                        mem_addr <= sp_dec;
                        mem_wdata <= push_next;
                        push_step <= push_step + 3'h1;
                    end else begin
                        mem_we <= 1'b0;
                        mem_re <= 1'b1;
                        mem_addr <= TRAP_VECTOR;
                        flag_register[`CSTO_FLAG_I] <= 1'b1;
                        push_step <= 3'h0;
                        state <= S_VECH;
                    end
                end
                // vector high byte, then low byte
                S_VECH: begin
                    vec_hi <= mem_rdata;
                    mem_addr <= TRAP_VECTOR + `CSTO_ONE16;
                    state <= S_VECL;
                end
                S_VECL: begin
                    prog_ctr <= {vec_hi, mem_rdata};
                    mem_re <= 1'b0;
                    state <= S_PAD;
                end
                // idle cycle that fills out the documented count
                S_PAD: begin
                    mem_addr <= prog_ctr;
                    mem_re <= 1'b1;
                    state <= S_FETCH;
                end
                default: begin
                    mem_addr <= prog_ctr;
                    mem_re <= 1'b1;
                    mem_we <= 1'b0;
                    state <= S_FETCH;
                end
            endcase
        end
    end
endmodule // csto_core

// ---- shared/csto_defines.vh ----
`ifndef CSTO_DEFINES_VH
`define CSTO_DEFINES_VH

// ****************************************
// opcodes: subtract group
// ****************************************
`define CSTO_SUB_IMMEDIATE 8'hA0
`define CSTO_SUB_DIRECT 8'hB0
`define CSTO_SUB_LONG 8'hC0
`define CSTO_SUB_INDEX_WIDE 8'hD0
`define CSTO_SUB_INDEX_BYTE 8'hE0
`define CSTO_SUB_INDEX_PLAIN 8'hF0
`define CSTO_SUB_STACK_BYTE 8'hE0
`define CSTO_SUB_STACK_WIDE 8'hD0

// ****************************************
// opcodes: zero/negative probe group
// ****************************************
`define CSTO_PROBE_DIRECT 8'h3D
`define CSTO_PROBE_ACC 8'h4D
`define CSTO_PROBE_INDEX 8'h5D
`define CSTO_PROBE_INDEX_BYTE 8'h6D
`define CSTO_PROBE_INDEX_PLAIN 8'h7D
`define CSTO_PROBE_STACK_BYTE 8'h6D

// ****************************************
// opcodes: trap, transfers, prefix
// ****************************************
`define CSTO_SOFTWARE_TRAP_OP 8'h83
`define CSTO_ACC_TO_FLAGS_OP 8'h84
`define CSTO_FLAGS_TO_ACC_OP 8'h85
`define CSTO_ACC_TO_INDEX_OP 8'h97
`define CSTO_INDEX_TO_ACC_OP 8'h9F
`define CSTO_STACK_TO_INDEX_OP 8'h95
`define CSTO_INDEX_TO_STACK_OP 8'h94
`define CSTO_STACK_PREFIX 8'h9E

// ****************************************
// flag register layout and reset values
// ****************************************
`define CSTO_FLAG_V 7
`define CSTO_FLAG_H 4
`define CSTO_FLAG_I 3
`define CSTO_FLAG_N 2
`define CSTO_FLAG_Z 1
`define CSTO_FLAG_C 0
`define CSTO_FLAGS_FIXED 8'h60
`define CSTO_FLAGS_RESET 8'h68
`define CSTO_STACK_RESET 16'h00FF

// ****************************************
// address base selects and counts
// ****************************************
`define CSTO_BASE_ABS 2'h0
`define CSTO_BASE_INDEX 2'h1
`define CSTO_BASE_STACK 2'h2
`define CSTO_PUSH_LAST 3'h4
`define CSTO_ONE16 16'h0001
`define CSTO_ZERO8 8'h00
`define CSTO_ZERO16 16'h0000

`endif

// ---- design/csto_sub_flags.v ----
`timescale 1ns/1ns
`include "csto_defines.vh"

// ****************************************
// subtractor with result flags
// ****************************************
module csto_sub_flags #(
    parameter WIDTH = 8
) (
    // operands
    input wire [WIDTH-1:0] minuend,
    input wire [WIDTH-1:0] subtrahend,
    // result and flags
    output wire [WIDTH-1:0] diff,
    output wire ovf,
    output wire neg,
    output wire zero,
    output wire borrow
);
    // one extra bit catches the borrow
    wire [WIDTH:0] full;

    assign full = {1'b0, minuend} - {1'b0, subtrahend};
    assign diff = full[WIDTH-1:0];
    assign borrow = full[WIDTH];
    assign neg = full[WIDTH-1];
    assign zero = (full[WIDTH-1:0] == {WIDTH{1'b0}});
    // signed overflow: operand signs differ and result sign flips
    assign ovf = (minuend[WIDTH-1] & ~subtrahend[WIDTH-1] & ~full[WIDTH-1])
        | (~minuend[WIDTH-1] & subtrahend[WIDTH-1] & full[WIDTH-1]);
endmodule // csto_sub_flags

// ---- verif/csto_core_assertions.sv ----
`timescale 1ns/1ns

// ****************************************
// checker on the core ports
// ****************************************
module csto_core_checker #(
    parameter [15:0] RESET_PC = 16'h0000,
    parameter [15:0] TRAP_VECTOR = 16'hFFFC
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // core memory bus
    input wire [7:0] mem_rdata,
    input wire [15:0] mem_addr,
    input wire [7:0] mem_wdata,
    input wire mem_re,
    input wire mem_we,
    // visible core state
    input wire [7:0] acc,
    input wire [15:0] index_reg,
    input wire [15:0] stack_ptr,
    input wire [15:0] prog_ctr,
    input wire [7:0] flag_register
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // two vector reads then one idle bus cycle
    sequence vector_fetch;
        !mem_we && mem_re && mem_addr == TRAP_VECTOR
        ##1 mem_re && mem_addr == TRAP_VECTOR + 16'h0001
        ##1 !mem_re && !mem_we;
    endsequence

    // first push at the old stack top, then index low, acc, flags
    sequence regs_pushed;
        mem_addr == stack_ptr ##2 mem_wdata == index_reg[7:0]
        ##1 mem_wdata == acc ##1 mem_wdata == flag_register;
    endsequence

    trap_sequence_a: assert property (
        $rose(mem_we) |-> mem_we[*5] ##1 vector_fetch ##1 (mem_re && mem_addr == $past(prog_ctr)))
        else $error("trap bus sequence broken");
    push_data_a: assert property (
        $rose(mem_we) |-> regs_pushed)
        else $error("pushed byte wrong");
    push_addr_a: assert property (
        mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) - 16'h0001)
        else $error("push address not descending");
    stack_drop_a: assert property (
        $fell(mem_we) |-> stack_ptr == $past(mem_addr) - 16'h0001)
        else $error("stack pointer not below last push");
    mask_set_a: assert property (
        $fell(mem_we) |-> flag_register == ($past(flag_register) | 8'h08))
        else $error("trap flags wrong");
    fixed_bits_a: assert property (
        flag_register[6:5] == 2'h3)
        else $error("fixed flag bits lost");
    bus_exclusive_a: assert property (
        !(mem_re && mem_we))
        else $error("read and write together");
    stack_move_a: assert property (
        $changed(stack_ptr) && !$past(mem_we) |-> stack_ptr == $past(index_reg) - 16'h0001)
        else $error("stack pointer not index minus one");
endmodule // csto_core_checker

bind csto_core csto_core_checker #(
    .RESET_PC(RESET_PC),
    .TRAP_VECTOR(TRAP_VECTOR)
) checker_i (
    .clk(clk),
    .rst_b(rst_b),
    .mem_rdata(mem_rdata),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_re(mem_re),
    .mem_we(mem_we),
    .acc(acc),
    .index_reg(index_reg),
    .stack_ptr(stack_ptr),
    .prog_ctr(prog_ctr),
    .flag_register(flag_register)
);

// ---- verif/csto_mem_model.sv ----
`timescale 1ns/1ns

// ****************************************
// zero-wait memory on the core bus
// ****************************************
module csto_mem_model (
    // clock
    input wire clk,
    // core memory bus
    input wire [15:0] mem_addr,
    input wire [7:0] mem_wdata,
    input wire mem_re,
    input wire mem_we,
    output wire [7:0] mem_rdata
);
    logic [7:0] bytes [0:65535]; // whole address space
    logic [7:0] last; // byte shown in the previous cycle

    // idle cycles show the inverse of the last byte, so a stale read cannot pass
    assign mem_rdata = mem_re ? bytes[mem_addr] : ~last;

    // clear at start; the bench loads its image one step later
    initial begin
        last = 8'h00;
        foreach (bytes[i]) bytes[i] = 8'h00;
    end

    // write lands at the edge that ends the cycle
    always @(posedge clk) begin
        last <= mem_rdata;
        if (mem_we) begin
            bytes[mem_addr] <= mem_wdata;
        end
    end
endmodule // csto_mem_model

// ---- verif/cpu_subtract_trap_test_ops_test.sv ----
`timescale 1ns/1ns

// ****************************************
// bench for the core slice
// ****************************************
module cpu_subtract_trap_test_ops_test;
    typedef struct packed {
        logic [31:0] code; // opcode bytes, left aligned
        logic [2:0] len;
        logic [3:0] cyc;
        logic [7:0] acc;
        logic [7:0] fl;
        logic [15:0] hx;
        logic [15:0] sp;
        logic [15:0] nx; // address of the next opcode fetch
    } csto_row_t;

    logic clk;
    logic rst_b;
    wire [7:0] mem_rdata;
    wire [15:0] mem_addr;
    wire [7:0] mem_wdata;
    wire mem_re;
    wire mem_we;
    wire [7:0] acc;
    wire [15:0] index_reg;
    wire [15:0] stack_ptr;
    wire [15:0] prog_ctr;
    wire [7:0] flag_register;
    int mismatches;
    int n_compared;
    csto_row_t rows [0:23];
    logic [23:0] data_tab [0:13]; // address and byte of operand data
    logic [7:0] pushed [0:4]; // stacked bytes from 007F down

    csto_core DUT (.clk(clk), .rst_b(rst_b), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_we(mem_we), .acc(acc),
        .index_reg(index_reg), .stack_ptr(stack_ptr), .prog_ctr(prog_ctr),
        .flag_register(flag_register));
    csto_mem_model mem (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_re(mem_re), .mem_we(mem_we), .mem_rdata(mem_rdata));

    // one compare, counted
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // values held while reset is low
    task check_reset;
        check("acc", acc, 16'h0000);
        check("flags", flag_register, 16'h0068);
        check("hx", index_reg, 16'h0000);
        check("sp", stack_ptr, 16'h00FF);
        check("we", mem_we, 16'h0000);
        check("re", mem_re, 16'h0001);
        check("addr", mem_addr, 16'h0000);
    endtask

    task summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // a hang is cut short well past the expected run
    initial begin
        repeat (1000) @(posedge clk);
        mismatches++;
        summarize;
    end

    // main sequence
    initial begin
        logic [15:0] a;
        rst_b = 1'b0;
        mismatches = 0;
        n_compared = 0;
        rows = '{
            '{32'hA0800000, 3'h2, 4'h2, 8'h80, 8'hED, 16'h0000, 16'h00FF, 16'h0002},
            '{32'h97000000, 3'h1, 4'h1, 8'h80, 8'hED, 16'h0080, 16'h00FF, 16'h0003},
            '{32'h4D000000, 3'h1, 4'h1, 8'h80, 8'h6D, 16'h0080, 16'h00FF, 16'h0004},
            '{32'hB0500000, 3'h2, 4'h3, 8'h00, 8'h6A, 16'h0080, 16'h00FF, 16'h0006},
            '{32'h5D000000, 3'h1, 4'h1, 8'h00, 8'h6C, 16'h0080, 16'h00FF, 16'h0007},
            '{32'h3D510000, 3'h2, 4'h3, 8'h00, 8'h6A, 16'h0080, 16'h00FF, 16'h0009},
            '{32'hC0123400, 3'h3, 4'h4, 8'hFF, 8'h6D, 16'h0080, 16'h00FF, 16'h000C},
            '{32'h94000000, 3'h1, 4'h2, 8'hFF, 8'h6D, 16'h0080, 16'h007F, 16'h000D},
            '{32'h85000000, 3'h1, 4'h1, 8'h6D, 8'h6D, 16'h0080, 16'h007F, 16'h000E},
            '{32'h97000000, 3'h1, 4'h1, 8'h6D, 8'h6D, 16'h006D, 16'h007F, 16'h000F},
            '{32'h95000000, 3'h1, 4'h2, 8'h6D, 8'h6D, 16'h0080, 16'h007F, 16'h0010},
            '{32'h9F000000, 3'h1, 4'h1, 8'h80, 8'h6D, 16'h0080, 16'h007F, 16'h0011},
            '{32'hD0010000, 3'h3, 4'h4, 8'h01, 8'hE8, 16'h0080, 16'h007F, 16'h0014},
            '{32'hE0100000, 3'h2, 4'h3, 8'h81, 8'hED, 16'h0080, 16'h007F, 16'h0016},
            '{32'hF0000000, 3'h1, 4'h2, 8'h80, 8'h6C, 16'h0080, 16'h007F, 16'h0017},
            '{32'h7D000000, 3'h1, 4'h2, 8'h80, 8'h68, 16'h0080, 16'h007F, 16'h0018},
            '{32'h6D100000, 3'h2, 4'h3, 8'h80, 8'h6C, 16'h0080, 16'h007F, 16'h001A},
            '{32'h9EE00500, 3'h3, 4'h4, 8'h70, 8'hE8, 16'h0080, 16'h007F, 16'h001D},
            '{32'h9ED00006, 3'h4, 4'h5, 8'h00, 8'h6A, 16'h0080, 16'h007F, 16'h0021},
            '{32'h9E6D0400, 3'h3, 4'h4, 8'h00, 8'h6C, 16'h0080, 16'h007F, 16'h0024},
            '{32'hA0090000, 3'h2, 4'h2, 8'hF7, 8'h6D, 16'h0080, 16'h007F, 16'h0026},
            '{32'h84000000, 3'h1, 4'h2, 8'hF7, 8'hF7, 16'h0080, 16'h007F, 16'h0027},
            '{32'hA00F0000, 3'h2, 4'h2, 8'hE8, 8'h74, 16'h0080, 16'h007F, 16'h0029},
            '{32'h83000000, 3'h1, 4'h9, 8'hE8, 8'h7C, 16'h0080, 16'h007A, 16'h4000}};
        // byte-swapped addresses hold decoys so a wrong order shows up
        data_tab = '{24'h005080, 24'h005100, 24'h123401, 24'h341202, 24'h01807F, 24'h008133,
            24'h009080, 24'h008001, 24'h008410, 24'h008570, 24'h067F11, 24'h0083F0,
            24'hFFFC40, 24'hFFFD00};
        pushed = '{8'h2A, 8'h00, 8'h80, 8'hE8, 8'h74};
        #1;
        a = 16'h0000;
        foreach (rows[r]) begin
            for (int k = 0; k < rows[r].len; k++) begin
                mem.bytes[a] = rows[r].code[31 - 8 * k -: 8];
                a++;
            end
        end
        foreach (data_tab[d]) mem.bytes[data_tab[d][23:8]] = data_tab[d][7:0];
        repeat (15) @(posedge clk);
        #1;
        check_reset;
        @(posedge clk);
        rst_b <= 1'b1;
        // one row per instruction, executed back to back
        foreach (rows[r]) begin
            repeat (rows[r].cyc) @(posedge clk);
            #1;
            check("acc", acc, {8'h00, rows[r].acc});
            check("flags", flag_register, {8'h00, rows[r].fl});
            check("hx", index_reg, rows[r].hx);
            check("sp", stack_ptr, rows[r].sp);
            check("next fetch", mem_addr, rows[r].nx);
            check("pc", prog_ctr, rows[r].nx);
        end
        // stacked bytes after the trap
        for (int p = 0; p < 5; p++) begin
            check("stacked", mem.bytes[16'h007F - p], {8'h00, pushed[p]});
        end
        // second reset in mid-run, then the first row again
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_reset;
        // release on an edge, as every other input is driven
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("acc again", acc, 16'h0080);
        check("fetch again", mem_addr, 16'h0002);
        summarize;
    end
endmodule // cpu_subtract_trap_test_ops_test
